/* core/boot_ctrl.sv */
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module boot_ctrl (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // pins from outside
   input wire logic prog_sel_pin,
   input wire logic por_active,
   input wire logic [2:0] low_supply_detector,
   // register bus
   input wire boot_ctrl_pkg::avl_req_t avl_req,
   output boot_ctrl_pkg::avl_rsp_t avl_rsp,
   // programming tool option and memory access
   input wire logic prog_opt_we,
   input wire logic [7:0] prog_opt_wdata,
   input wire logic prog_mem_req,
   output logic prog_mem_grant,
   // chip control
   output logic chip_rst,
   output logic i2c_prog_en,
   output logic cpu_run,
   output logic [12:0] fetch_addr,
   output boot_ctrl_pkg::clk_sel_t clk_sel
);
   import boot_ctrl_pkg::*;

   // =========================================
   // pin synchronisers
   logic [1:0] sel_sync_reg, sel_sync_next;
   logic [1:0] por_sync_reg, por_sync_next;
   logic [2:0] lvd_s1_reg, lvd_s1_next, lvd_s2_reg, lvd_s2_next;

   always_comb begin
      sel_sync_next = {sel_sync_reg[0], prog_sel_pin};
      por_sync_next = {por_sync_reg[0], por_active};
      lvd_s1_next = low_supply_detector;
      lvd_s2_next = lvd_s1_reg;
   end

   always_ff @(posedge clk_sys) begin
      sel_sync_reg <= sel_sync_next;
      por_sync_reg <= por_sync_next;
      lvd_s1_reg <= lvd_s1_next;
      lvd_s2_reg <= lvd_s2_next;
   end

   // =========================================
   // reset combining
   logic [7:0] option_reg, option_next;
   logic [3:0] por_cnt_reg, por_cnt_next;
   logic lvd_trip;
   logic int_rst;

   always_comb begin
      // threshold chosen by option; setting 3 disables the detector
      case (option_reg[OPT_LVD_LSB +: 2])
         2'h0: lvd_trip = lvd_s2_reg[0];
         2'h1: lvd_trip = lvd_s2_reg[1];
         2'h2: lvd_trip = lvd_s2_reg[2];
         LVD_OFF: lvd_trip = 1'b0;
         default: lvd_trip = 1'b0;
      endcase
      // stretch keeps reset high past a short power glitch
      if (por_sync_reg[1] || lvd_trip) begin
         por_cnt_next = POR_CYCLES;
      end else if (por_cnt_reg != 4'h0) begin
         por_cnt_next = por_cnt_reg - 4'h1;
      end else begin
         por_cnt_next = por_cnt_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         por_cnt_reg <= POR_CYCLES;
      end else begin
         por_cnt_reg <= por_cnt_next;
      end
   end

   // pin reset, power-on and low supply all land on one reset
   assign int_rst = sys_rst || (por_cnt_reg != 4'h0);

   // =========================================
   // mode state machine
   boot_state_t state_reg, state_next;
   logic prog_mode_reg, prog_mode_next;
   clk_sel_t clk_sel_reg, clk_sel_next;

   always_comb begin
      state_next = state_reg;
      prog_mode_next = prog_mode_reg;
      clk_sel_next = clk_sel_reg;
      case (state_reg)
         ST_RESET: begin
            clk_sel_next = CLK_INTERNAL;
            state_next = ST_SAMPLE;
         end
         ST_SAMPLE: begin
            // single sample; later pin moves are ignored until reset
            prog_mode_next = sel_sync_reg[1];
            if (sel_sync_reg[1]) begin
               state_next = ST_PROG;
            end else begin
               state_next = ST_WORK;
               clk_sel_next = clk_sel_t'(option_reg[OPT_CLK_LSB +: 2]);
            end
         end
         ST_PROG: begin
            clk_sel_next = CLK_INTERNAL;
         end
         ST_WORK: begin
            state_next = ST_WORK;
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (int_rst) begin
         state_reg <= ST_RESET;
         prog_mode_reg <= 1'b0;
         clk_sel_reg <= CLK_INTERNAL;
      end else begin
         state_reg <= state_next;
         prog_mode_reg <= prog_mode_next;
         clk_sel_reg <= clk_sel_next;
      end
   end

   // =========================================
   // option byte store
   logic retry_reg, retry_next;

   always_comb begin
      option_next = option_reg;
      // only the programming tool path writes; running code cannot
      if (state_reg == ST_PROG && prog_opt_we) begin
         option_next = prog_opt_wdata;
      end
   end

   // option byte survives pin reset: only power-on reset clears it
   always_ff @(posedge clk_sys) begin
      if (por_sync_reg[1]) begin
         option_reg <= OPTION_RESET;
      end else begin
         option_reg <= option_next;
      end
   end

   // =========================================
   // avalon slave, zero wait states
   logic [31:0] rdata_reg, rdata_next;
   logic [31:0] status_word;

   always_comb begin
      status_word = 32'h00000000;
      status_word[ST_PROG_BIT] = prog_mode_reg;
      status_word[ST_RUN_BIT] = (state_reg == ST_WORK);
      status_word[ST_CLK_LSB +: 2] = clk_sel_reg;
      status_word[ST_LOCK_BIT] = option_reg[OPT_LOCK_BIT];
      rdata_next = rdata_reg;
      retry_next = retry_reg;
      if (avl_req.read) begin
         case (avl_req.address)
            ADDR_CTRL: rdata_next = {31'h00000000, retry_reg};
            ADDR_STATUS: rdata_next = status_word;
            ADDR_OPTION: rdata_next = {24'h000000, option_reg};
            default: rdata_next = UNMAPPED_READ;
         endcase
      end
      // writes to the option word are dropped: it is read-only on the bus
      if (avl_req.write && avl_req.address == ADDR_CTRL) begin
         retry_next = avl_req.writedata[CTRL_RETRY_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_reg <= 32'h00000000;
         retry_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         retry_reg <= retry_next;
      end
   end

   // readdata is combinational so the read completes in the request cycle
   always_comb begin
      avl_rsp.waitrequest = 1'b0;
      avl_rsp.readdata = rdata_next;
   end

   // =========================================
   // outputs
   always_comb begin
      chip_rst = int_rst || state_reg == ST_RESET || state_reg == ST_SAMPLE;
      i2c_prog_en = (state_reg == ST_PROG);
      cpu_run = (state_reg == ST_WORK);
      fetch_addr = FETCH_START;
      clk_sel = clk_sel_reg;
      prog_mem_grant = (state_reg == ST_PROG) && prog_mem_req
                       && !option_reg[OPT_LOCK_BIT];
   end

endmodule : boot_ctrl

/* core/boot_ctrl_pkg.sv */
// Behaviour
// - selector pin low selects working mode, running user code.
// - selector pin high selects memory programming mode.
// - mode changes only through a reset after the selector pin moves.
// - option byte writes accepted only in programming mode, frozen in working mode.
// - programming traffic uses the i2c pins; reset starts the protocol cleanly.
// - programming mode always runs on the internal oscillator.
// - after reset start on internal oscillator, then apply option clock mode.
// - working mode fetch begins at the first memory location.
// - power-on reset holds the internal chip reset during power-up.
// - low supply detector resets chip; threshold one of three settings.
// - memory lock refuses external memory access through programming interface.
package boot_ctrl_pkg;

   // =========================================
   // register map
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_OPTION = 4'h8;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

   // =========================================
   // option byte fields
   localparam int OPT_CLK_LSB = 0;
   localparam int OPT_LVD_LSB = 2;
   localparam int OPT_LOCK_BIT = 4;
   localparam logic [7:0] OPTION_RESET = 8'h00;
   localparam logic [1:0] LVD_OFF = 2'h3;

   // =========================================
   // status fields
   localparam int ST_PROG_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_CLK_LSB = 2;
   localparam int ST_LOCK_BIT = 4;

   // =========================================
   // control fields
   localparam int CTRL_RETRY_BIT = 0;

   localparam logic [12:0] FETCH_START = 13'h0000;
   localparam logic [3:0] POR_CYCLES = 4'hF;

   typedef enum logic [1:0] {
      CLK_INTERNAL = 2'h0,
      CLK_EXTERNAL = 2'h1,
      CLK_CRYSTAL = 2'h2
   } clk_sel_t;

   typedef enum logic [3:0] {
      ST_RESET = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_PROG = 4'b0100,
      ST_WORK = 4'b1000
   } boot_state_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avl_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avl_rsp_t;

endpackage : boot_ctrl_pkg

/* verification/boot_ctrl_properties.sv */
`timescale 1ns/1ps
// ====
// start-up mode checks
module boot_ctrl_properties (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // watched pins
   input wire logic por_active,
   input wire logic prog_mem_req,
   input wire logic prog_mem_grant,
   input wire logic chip_rst,
   input wire logic i2c_prog_en,
   input wire logic cpu_run,
   input wire logic [12:0] fetch_addr,
   input wire boot_ctrl_pkg::clk_sel_t clk_sel
);
   import boot_ctrl_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   one_mode_a: assert property (!(cpu_run && i2c_prog_en))
      else $error("both modes");
   // five quiet cycles skip the first one, where the mode output rises
   mode_fixed_a: assert property ((!chip_rst) [*5]
      |-> $stable(cpu_run) && $stable(i2c_prog_en))
      else $error("mode moved");
   mode_entry_a: assert property ($fell(chip_rst) |-> ##[0:3] (cpu_run || i2c_prog_en))
      else $error("no mode");
   grant_gate_a: assert property (prog_mem_grant |-> i2c_prog_en && prog_mem_req)
      else $error("bad grant");
   fetch_start_a: assert property (cpu_run |-> fetch_addr == FETCH_START)
      else $error("bad fetch");
   prog_clock_a: assert property (i2c_prog_en |-> clk_sel == CLK_INTERNAL)
      else $error("prog clock");
   // the clock select only follows a reset one cycle late, so skip its first cycle
   reset_clock_a: assert property (chip_rst && $past(chip_rst) |-> clk_sel == CLK_INTERNAL)
      else $error("start clock");
   por_reset_a: assert property ($rose(por_active) |-> ##[1:4] chip_rst)
      else $error("no por reset");
   halt_cpu_a: assert property ($rose(chip_rst) |-> ##[0:2] !cpu_run && !i2c_prog_en)
      else $error("still running");
endmodule : boot_ctrl_properties
bind boot_ctrl boot_ctrl_properties u_props (.clk_sys, .sys_rst, .por_active, .prog_mem_req,
   .prog_mem_grant, .chip_rst, .i2c_prog_en, .cpu_run, .fetch_addr, .clk_sel);

/* verification/boot_ctrl_tb_top.sv */
`timescale 1ns/1ps
// ====
// start-up bench
module boot_ctrl_tb_top;
   import boot_ctrl_pkg::*;
   logic clk_sys, sys_rst, prog_sel_pin, por_active, opt_we, mem_req;
   logic prog_mem_grant, chip_rst, i2c_prog_en, cpu_run;
   logic [2:0] low_supply_detector;
   logic [7:0] opt_wdata, opt;
   logic [12:0] fetch_addr;
   logic [31:0] q;
   avl_req_t avl_req;
   avl_rsp_t avl_rsp;
   clk_sel_t clk_sel;
   int seed = 55858;
   int miscompares = 0;
   int num_checks = 0;
   int k;
   prog_tool tool (.clk_sys, .opt_we, .opt_wdata, .mem_req);
   boot_ctrl DUT (.clk_sys, .sys_rst, .prog_sel_pin, .por_active, .low_supply_detector,
      .avl_req, .avl_rsp, .prog_opt_we(opt_we), .prog_opt_wdata(opt_wdata),
      .prog_mem_req(mem_req), .prog_mem_grant, .chip_rst, .i2c_prog_en, .cpu_run,
      .fetch_addr, .clk_sel);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic [31:0] exp_status(input logic p, input logic r, input logic [1:0] c,
      input logic l);
      logic [31:0] v;
      v = 32'h00000000;
      v[ST_PROG_BIT] = p;
      v[ST_RUN_BIT] = r;
      v[ST_CLK_LSB +: 2] = c;
      v[ST_LOCK_BIT] = l;
      return v;
   endfunction : exp_status
   task results;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avl_req <= {a, !w, w, d};
      do @(posedge clk_sys); while (avl_rsp.waitrequest !== 1'b0);
      q = avl_rsp.readdata;
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
   endtask : bus
   task boot(input logic sel, input logic por);
      prog_sel_pin <= sel;
      por_active <= por;
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      por_active <= 1'b0;
      // own loop index: k carries the chosen supply threshold across boots
      for (int i = 0; i < 60 && cpu_run !== 1'b1 && i2c_prog_en !== 1'b1; i++)
         @(posedge clk_sys);
      chk("mode", {cpu_run, i2c_prog_en}, {!sel, sel});
   endtask : boot
   initial begin
      sys_rst = 1'b1;
      prog_sel_pin = 1'b0;
      por_active = 1'b1;
      low_supply_detector = 3'h0;
      avl_req = '0;
      boot(1'b0, 1'b1);
      chk("fetch", fetch_addr, FETCH_START);
      opt = 8'($random(seed));
      bus(1'b1, ADDR_CTRL, {24'h0, opt});
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk("scratch", q, {31'h0, opt[CTRL_RETRY_BIT]});
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status work", q, exp_status(1'b0, 1'b1, CLK_INTERNAL, 1'b0));
      tool.put_opt(8'($random(seed)));
      bus(1'b1, ADDR_OPTION, 32'h1F);
      bus(1'b1, 4'hC, 32'h1F);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", q, UNMAPPED_READ);
      bus(1'b0, ADDR_OPTION, 32'h0);
      chk("frozen", q, {24'h0, OPTION_RESET});
      repeat (20) begin
         @(posedge clk_sys);
         prog_sel_pin <= 1'($random(seed));
      end
      chk("held", cpu_run, 1'b1);
      boot(1'b1, 1'b0);
      k = $unsigned($random(seed)) % 3;
      opt = {4'h0, 2'(k), 2'(1 + k % 2)};
      tool.put_opt(opt);
      bus(1'b0, ADDR_OPTION, 32'h0);
      chk("option", q, {24'h0, opt});
      chk("prog clk", clk_sel, CLK_INTERNAL);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status prog", q, exp_status(1'b1, 1'b0, CLK_INTERNAL, 1'b0));
      tool.ask(1'b1);
      @(posedge clk_sys);
      chk("grant", prog_mem_grant, 1'b1);
      tool.put_opt(opt | 8'h10);
      @(posedge clk_sys);
      chk("lock", prog_mem_grant, 1'b0);
      tool.ask(1'b0);
      boot(1'b0, 1'b0);
      repeat (2) @(posedge clk_sys);
      chk("work clk", clk_sel, opt[1:0]);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status lock", q, exp_status(1'b0, 1'b1, opt[1:0], 1'b1));
      low_supply_detector[(k + 1) % 3] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk("other lvd", chip_rst, 1'b0);
      low_supply_detector[k] <= 1'b1;
      for (int i = 0; i < 8 && chip_rst !== 1'b1; i++) @(posedge clk_sys);
      chk("trip", chip_rst, 1'b1);
      low_supply_detector <= 3'h0;
      for (int i = 0; i < 40 && cpu_run !== 1'b1; i++) @(posedge clk_sys);
      chk("recover", cpu_run, 1'b1);
      // power-on pulse while running, outside the pin reset
      por_active <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk("por", chip_rst, 1'b1);
      boot(1'b0, 1'b1);
      bus(1'b0, ADDR_OPTION, 32'h0);
      chk("por opt", q, {24'h0, OPTION_RESET});
      results();
   end
   // far beyond the few hundred cycles the sequence needs
   initial begin
      #(40 * 4000);
      miscompares++;
      results();
   end
endmodule : boot_ctrl_tb_top

/* verification/prog_tool.sv */
`timescale 1ns/1ps
// ====
// programming tool side
module prog_tool (
   // clock
   input wire logic clk_sys,
   // tool lines
   output logic opt_we,
   output logic [7:0] opt_wdata,
   output logic mem_req
);
   initial begin
      opt_we = 1'b0;
      opt_wdata = 8'h00;
      mem_req = 1'b0;
   end
   // data turns to junk after the strobe, so a stale byte cannot pass
   task put_opt(input logic [7:0] v);
      @(posedge clk_sys);
      opt_we <= 1'b1;
      opt_wdata <= v;
      @(posedge clk_sys);
      opt_we <= 1'b0;
      opt_wdata <= ~v;
   endtask : put_opt
   task ask(input logic v);
      @(posedge clk_sys);
      mem_req <= v;
   endtask : ask
endmodule : prog_tool
